// [logic/ils_line_sync.sv]
/*
  Instruction-cache line sync unit: effective address, translation check, data writeback and
  instruction-line invalidate for one line, with exception reporting.
  Assumes the pipeline holds a request until done, and the caches answer with one-cycle acks.
*/
`timescale 1ns/10ps
`include "ils_consts.svh"

// What this block does
// - Effective address is base register plus sign-extended 16-bit offset.
// - Only the single line holding that address is acted on, in every cache.
// - Second-release parts run it in every mode, no privilege check.
// - First-release parts raise reserved-instruction instead.
// - Translation faults are refill or invalid with load cause only.
// - Writeback cache or bus error raises cache error.
// - A bus transaction ending in error may raise bus error.
// - Faulting kernel addresses may raise address error with load cause.
// - Data watch triggering is a documented fixed choice.
// - Broadcast to coherent icaches only for coherent attribute.
// - All affected cache levels are treated alike.
// - With hardware-coherent icaches the operation is a no-op.
// - Locked lines are left untouched.
// - At least the own caches are synchronized.
// - Step size is readable; zero means no sync needed.
module ils_line_sync
  import ils_pkg::*;
#(
  parameter int ADDR_W = 64,
  parameter bit RELEASE2 = 1'b1,
  parameter bit HW_COHERENT_IC = 1'b0,
  parameter bit KSEG_CHECK = 1'b1,
  parameter logic [15:0] STEP_SIZE = `ILS_STEP_RESET
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Request from pipeline
  input wire logic req_valid,
  input wire logic [ADDR_W-1:0] base_value,
  input wire logic [`ILS_OFFSET_W-1:0] offset_field,
  input wire logic user_mode,
  output logic req_ready,
  output logic done,
  output ils_exc_rep_t exc_rep_ff,
  output logic watch_hit,
  output logic [15:0] sync_step_size_register,
  // Translation
  output logic xlate_req,
  output logic [ADDR_W-1:0] vaddr_ff,
  input wire logic xlate_ack,
  input wire logic xlate_miss,
  input wire logic xlate_invalid,
  input wire logic xlate_coherent,
  // Cache hierarchy
  output logic wb_req,
  output logic inv_req,
  output logic broadcast_ff,
  input wire logic line_locked,
  input wire logic wb_ack,
  input wire logic wb_cache_err,
  input wire logic wb_bus_err,
  input wire logic inv_ack,
  input wire logic inv_bus_err
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ils_state_t state_ff;
  ils_state_t nxt_state;
  logic [ADDR_W-1:0] nxt_vaddr;
  logic kseg_fault;

  // Step size reported to software, constant per build
  assign sync_step_size_register = HW_COHERENT_IC ? 16'h0000 : STEP_SIZE;
  // Data watch never triggered by this operation
  assign watch_hit = `ILS_WATCH_TRIGGERS;

  // Effective address from base and sign-extended offset
  assign nxt_vaddr = base_value + {{(ADDR_W-`ILS_OFFSET_W){offset_field[`ILS_OFFSET_SIGN]}}, offset_field};
  // Kernel region access from user mode faults
  assign kseg_fault = KSEG_CHECK && user_mode && vaddr_ff[ADDR_W-1];

  // Handshakes
  assign req_ready = (state_ff == ILS_IDLE);
  assign done = (state_ff == ILS_DONE);
  assign xlate_req = (state_ff == ILS_XLATE);
  assign wb_req = (state_ff == ILS_WBACK);
  assign inv_req = (state_ff == ILS_INVAL);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ILS_IDLE:
      begin
        if (req_valid)
        begin
          // No privilege check; first-release or coherent icaches end at once
          if (!RELEASE2 || HW_COHERENT_IC)
            nxt_state = ILS_DONE;
          else
            nxt_state = ILS_XLATE;
        end
      end
      ILS_XLATE:
      begin
        if (kseg_fault)
          nxt_state = ILS_DONE;
        else if (xlate_ack)
        begin
          if (xlate_miss || xlate_invalid || line_locked)
            nxt_state = ILS_DONE;
          else
            nxt_state = ILS_WBACK;
        end
      end
      ILS_WBACK:
      begin
        if (wb_ack)
          nxt_state = (wb_cache_err || wb_bus_err) ? ILS_DONE : ILS_INVAL;
      end
      ILS_INVAL:
      begin
        if (inv_ack)
          nxt_state = ILS_DONE;
      end
      ILS_DONE:
      begin
        nxt_state = ILS_IDLE;
      end
      default:
      begin
        nxt_state = ILS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_ff <= ILS_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Address and broadcast capture
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      vaddr_ff <= '0;
      broadcast_ff <= 1'b0;
    end
    else
    begin
      if (state_ff == ILS_IDLE && req_valid)
      begin
        vaddr_ff <= nxt_vaddr;
        broadcast_ff <= 1'b0;
      end
      else if (state_ff == ILS_XLATE && xlate_ack)
        broadcast_ff <= xlate_coherent;
    end
  end

  // Exception report, held until the next request
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      exc_rep_ff <= '{code: ILS_EXC_NONE, load_cause: 1'b0};
    else if (state_ff == ILS_IDLE && req_valid)
    begin
      // First-release builds report the instruction as reserved
      if (!RELEASE2)
        exc_rep_ff <= '{code: ILS_EXC_RSVD_INSTR, load_cause: 1'b0};
      else
        exc_rep_ff <= '{code: ILS_EXC_NONE, load_cause: 1'b0};
    end
    else if (state_ff == ILS_XLATE && kseg_fault)
      exc_rep_ff <= '{code: ILS_EXC_ADDR_ERR, load_cause: 1'b1};
    else if (state_ff == ILS_XLATE && xlate_ack && xlate_miss)
      exc_rep_ff <= '{code: ILS_EXC_TLB_REFILL, load_cause: 1'b1};
    else if (state_ff == ILS_XLATE && xlate_ack && xlate_invalid)
      exc_rep_ff <= '{code: ILS_EXC_TLB_INVALID, load_cause: 1'b1};
    else if (state_ff == ILS_WBACK && wb_ack && (wb_cache_err || wb_bus_err))
      exc_rep_ff <= '{code: ILS_EXC_CACHE_ERR, load_cause: 1'b0};
    else if (state_ff == ILS_INVAL && inv_ack && inv_bus_err)
      exc_rep_ff <= '{code: ILS_EXC_BUS_ERR, load_cause: 1'b0};
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ea_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == ILS_IDLE && req_valid) |=> vaddr_ff == $past(nxt_vaddr))
    else $error("effective address not captured");
  a_wb_before_inv: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(inv_req) |-> $past(wb_req))
    else $error("invalidate without writeback");
  a_rel1_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == ILS_IDLE && req_valid && !RELEASE2) |=> done && exc_rep_ff.code == ILS_EXC_RSVD_INSTR)
    else $error("reserved instruction missing");
  a_tlb_load: assert property (@(posedge ref_clk) disable iff (rst)
    (exc_rep_ff.code == ILS_EXC_TLB_REFILL || exc_rep_ff.code == ILS_EXC_TLB_INVALID) |-> exc_rep_ff.load_cause)
    else $error("translation fault without load cause");
  a_wb_err: assert property (@(posedge ref_clk) disable iff (rst)
    (wb_req && wb_ack && wb_cache_err) |=> done && exc_rep_ff.code == ILS_EXC_CACHE_ERR)
    else $error("cache error not raised");
  a_locked_skip: assert property (@(posedge ref_clk) disable iff (rst)
    (xlate_req && xlate_ack && line_locked && !kseg_fault) |=> !wb_req ##1 !inv_req)
    else $error("locked line touched");
  a_no_bcast: assert property (@(posedge ref_clk) disable iff (rst)
    (xlate_req && xlate_ack && !xlate_coherent) |=> !broadcast_ff)
    else $error("broadcast on non-coherent attribute");
  a_user_ok: assert property (@(posedge ref_clk) disable iff (rst)
    (req_ready && req_valid && user_mode && RELEASE2 && !HW_COHERENT_IC) |=> xlate_req)
    else $error("user-mode request not run");
  a_step_zero: assert property (@(posedge ref_clk) disable iff (rst)
    HW_COHERENT_IC |-> sync_step_size_register == 16'h0000)
    else $error("step size nonzero with coherent icaches");
endmodule // ils_line_sync

// [logic/ils_consts.svh]
/*
  Field positions, constants and reset values for the instruction-cache line sync unit.
  Assumes nothing; definitions only.
*/
`ifndef ILS_CONSTS_SVH
`define ILS_CONSTS_SVH
// ----------------------------------------------------------------
// Field positions and constants
// ----------------------------------------------------------------
`define ILS_OFFSET_W 16
`define ILS_OFFSET_SIGN 15
`define ILS_STEP_RESET 16'h0020
`define ILS_KSEG_TOP_BIT 63
`define ILS_WATCH_TRIGGERS 1'b0
`endif

// [logic/ils_pkg.sv]
/*
  Types for the instruction-cache line sync unit.
  Assumes the consts header supplies the numeric constants.
*/
package ils_pkg;
  // ----------------------------------------------------------------
  // Exception codes reported to the pipeline
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ILS_EXC_NONE = 3'h0,
    ILS_EXC_RSVD_INSTR = 3'h1,
    ILS_EXC_TLB_REFILL = 3'h2,
    ILS_EXC_TLB_INVALID = 3'h3,
    ILS_EXC_ADDR_ERR = 3'h4,
    ILS_EXC_CACHE_ERR = 3'h5,
    ILS_EXC_BUS_ERR = 3'h6
  } ils_exc_t;

  // Exception report: code plus load-cause flag
  typedef struct packed {
    ils_exc_t code;
    logic load_cause;
  } ils_exc_rep_t;

  // One-hot sequencer states
  typedef enum logic [4:0] {
    ILS_IDLE = 5'h01,
    ILS_XLATE = 5'h02,
    ILS_WBACK = 5'h04,
    ILS_INVAL = 5'h08,
    ILS_DONE = 5'h10
  } ils_state_t;
endpackage

// [tb/ils_cache_model.sv]
/*
  Cache and translation model facing the line sync unit.
  Assumes requests are levels held until their one-cycle ack.
*/
`timescale 1ns/10ps
module ils_cache_model
(
  // Clock
  input wire logic ref_clk,
  // Requests from the unit
  input wire logic xlate_req,
  input wire logic wb_req,
  input wire logic inv_req,
  // Answer shape from the bench
  input wire logic [6:0] cfg,
  input wire logic [1:0] dly,
  // Answers
  output logic xlate_ack,
  output logic xlate_miss,
  output logic xlate_invalid,
  output logic xlate_coherent,
  output logic line_locked,
  output logic wb_ack,
  output logic wb_cache_err,
  output logic wb_bus_err,
  output logic inv_ack,
  output logic inv_bus_err
);
  logic ack_ff = 1'b0;
  logic [1:0] cnt_ff = 2'h0;
  logic [6:0] flg;
  // Ack any request after dly cycles, for one cycle
  always @(negedge ref_clk)
    if (ack_ff || !(xlate_req || wb_req || inv_req))
    begin
      ack_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else if (cnt_ff == dly)
      ack_ff <= 1'b1;
    else
      cnt_ff <= cnt_ff + 2'h1;
  // Flags are only valid with an ack; inverted otherwise
  assign flg = ack_ff ? cfg : ~cfg;
  assign xlate_ack = ack_ff & xlate_req;
  assign wb_ack = ack_ff & wb_req;
  assign inv_ack = ack_ff & inv_req;
  assign xlate_miss = flg[0];
  assign xlate_invalid = flg[1];
  assign xlate_coherent = flg[2];
  assign line_locked = flg[3];
  assign wb_cache_err = flg[4];
  assign wb_bus_err = flg[5];
  assign inv_bus_err = flg[6];
endmodule // ils_cache_model

// [tb/tb_top.sv]
/*
  Self-checking bench for the line sync unit.
  Assumes default parameters and the cache model.
*/
`timescale 1ns/10ps
module tb_top
  import ils_pkg::*;
;
  logic ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, user_mode = 1'b0;
  logic [63:0] base_value = 64'h0;
  logic [15:0] offset_field = 16'h0, step;
  logic [6:0] cfg = 7'h0;
  logic [1:0] dly = 2'h0;
  logic req_ready, done, watch_hit, xlate_req, wb_req, inv_req, broadcast_ff;
  logic xa, xm, xi, xc, ll, wa, wce, wbe, ia, ibe;
  logic [63:0] vaddr_ff;
  ils_exc_rep_t exc_rep_ff;
  int n_fail = 0, num_checks = 0, wb_cnt = 0, inv_cnt = 0;
  logic r1_done, r1_xreq, hc_done, hc_xreq;
  logic [15:0] r1_step, hc_step;
  ils_exc_rep_t r1_exc, hc_exc;
  ils_line_sync ils_line_sync_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .base_value(base_value), .offset_field(offset_field), .user_mode(user_mode), .req_ready(req_ready),
    .done(done), .exc_rep_ff(exc_rep_ff), .watch_hit(watch_hit), .sync_step_size_register(step),
    .xlate_req(xlate_req), .vaddr_ff(vaddr_ff), .xlate_ack(xa), .xlate_miss(xm), .xlate_invalid(xi),
    .xlate_coherent(xc), .wb_req(wb_req), .inv_req(inv_req), .broadcast_ff(broadcast_ff),
    .line_locked(ll), .wb_ack(wa), .wb_cache_err(wce), .wb_bus_err(wbe), .inv_ack(ia), .inv_bus_err(ibe));
  ils_cache_model ils_cache_model_inst (.ref_clk(ref_clk), .xlate_req(xlate_req), .wb_req(wb_req),
    .inv_req(inv_req), .cfg(cfg), .dly(dly), .xlate_ack(xa), .xlate_miss(xm), .xlate_invalid(xi),
    .xlate_coherent(xc), .line_locked(ll), .wb_ack(wa), .wb_cache_err(wce), .wb_bus_err(wbe),
    .inv_ack(ia), .inv_bus_err(ibe));
  // First-release and hardware-coherent builds share the request pins and never reach the caches
  ils_line_sync #(.RELEASE2(1'b0)) ils_line_sync_rel1_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .base_value(base_value), .offset_field(offset_field), .user_mode(user_mode), .req_ready(), .done(r1_done),
    .exc_rep_ff(r1_exc), .watch_hit(), .sync_step_size_register(r1_step), .xlate_req(r1_xreq), .vaddr_ff(),
    .xlate_ack(xa), .xlate_miss(xm), .xlate_invalid(xi), .xlate_coherent(xc), .wb_req(), .inv_req(),
    .broadcast_ff(), .line_locked(ll), .wb_ack(wa), .wb_cache_err(wce), .wb_bus_err(wbe), .inv_ack(ia),
    .inv_bus_err(ibe));
  ils_line_sync #(.HW_COHERENT_IC(1'b1)) ils_line_sync_hc_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .base_value(base_value), .offset_field(offset_field), .user_mode(user_mode), .req_ready(), .done(hc_done),
    .exc_rep_ff(hc_exc), .watch_hit(), .sync_step_size_register(hc_step), .xlate_req(hc_xreq), .vaddr_ff(),
    .xlate_ack(xa), .xlate_miss(xm), .xlate_invalid(xi), .xlate_coherent(xc), .wb_req(), .inv_req(),
    .broadcast_ff(), .line_locked(ll), .wb_ack(wa), .wb_cache_err(wce), .wb_bus_err(wbe), .inv_ack(ia),
    .inv_bus_err(ibe));
  // ------------------------------------------------------------
  // Clock, writeback and invalidate counters, checks
  // ------------------------------------------------------------
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wb_req === 1'b1) wb_cnt <= wb_cnt + 1;
  always @(posedge ref_clk) if (inv_req === 1'b1) inv_cnt <= inv_cnt + 1;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One request, held until done, then judged
  task automatic run(input logic [63:0] b, input logic [15:0] o, input logic u, input logic [6:0] c,
    input ils_exc_t ec, input logic el, input logic eb, input logic ew);
    int n;
    int w0;
    int i0;
    n = 0;
    w0 = wb_cnt;
    i0 = inv_cnt;
    cfg = c;
    user_mode = u;
    base_value = b;
    offset_field = o;
    req_valid = 1'b1;
    do
    begin
      @(negedge ref_clk);
      n++;
      // Side builds finish one cycle after the take, without translating
      if (n == 1)
      begin
        chk(r1_done, 1'b1);
        chk(r1_exc.code, ILS_EXC_RSVD_INSTR);
        chk(r1_xreq, 1'b0);
        chk(hc_done, 1'b1);
        chk(hc_exc.code, ILS_EXC_NONE);
        chk(hc_xreq, 1'b0);
      end
    end
    while (done !== 1'b1 && n < 60);
    req_valid = 1'b0;
    chk(done, 1'b1);
    chk(vaddr_ff, b + {{48{o[15]}}, o});
    chk(exc_rep_ff.code, ec);
    if (el !== 1'bx) chk(exc_rep_ff.load_cause, el);
    if (eb !== 1'bx) chk(broadcast_ff, eb);
    chk(wb_cnt != w0, ew);
    chk(inv_cnt != i0, ew && !c[4] && !c[5]);
    // Idle gap stands for the barrier and hazard-clearing jump after a sync
    @(negedge ref_clk);
  endtask
  task automatic t_basic();
    dly = 2'h2;
    run(64'h1000, 16'hFFF0, 1'b1, 7'h04, ILS_EXC_NONE, 1'b0, 1'b1, 1'b1);
    dly = 2'h0;
    run(64'h7FFF, 16'h0011, 1'b0, 7'h00, ILS_EXC_NONE, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_faults();
    run(64'h40, 16'h8000, 1'b0, 7'h01, ILS_EXC_TLB_REFILL, 1'b1, 1'bx, 1'b0);
    run(64'h40, 16'h0004, 1'b0, 7'h02, ILS_EXC_TLB_INVALID, 1'b1, 1'bx, 1'b0);
    run(64'h40, 16'h0004, 1'b0, 7'h03, ILS_EXC_TLB_REFILL, 1'b1, 1'bx, 1'b0);
    run(64'h80, 16'h0000, 1'b0, 7'h10, ILS_EXC_CACHE_ERR, 1'bx, 1'bx, 1'b1);
    run(64'h80, 16'h0000, 1'b0, 7'h20, ILS_EXC_CACHE_ERR, 1'bx, 1'bx, 1'b1);
    run(64'h80, 16'h0000, 1'b0, 7'h40, ILS_EXC_BUS_ERR, 1'bx, 1'bx, 1'b1);
  endtask
  task automatic t_kern_lock();
    run(64'h8000_0000_0000_0000, 16'h0, 1'b1, 7'h0, ILS_EXC_ADDR_ERR, 1'b1, 1'bx, 1'b0);
    run(64'h8000_0000_0000_0000, 16'h0, 1'b0, 7'h0, ILS_EXC_NONE, 1'b0, 1'bx, 1'b1);
    run(64'h200, 16'h0, 1'b0, 7'h08, ILS_EXC_NONE, 1'b0, 1'bx, 1'b0);
  endtask
  task automatic t_step();
    chk(req_ready, 1'b1);
    chk(exc_rep_ff, 4'h0);
    chk(step, 16'h0020);
    chk(r1_step, 16'h0020);
    chk(hc_step, 16'h0000);
    chk(watch_hit, 1'b0);
    // Targets are data-only lines, never code run before the hazard clear
    for (int i = 0; i < 3; i++)
      run(64'h3000 + i * step, 16'h0, 1'b0, 7'h0, ILS_EXC_NONE, 1'b0, 1'b0, 1'b1);
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_step();
    t_basic();
    t_faults();
    t_kern_lock();
    results();
  end
  initial
  begin
    #20000;
    n_fail++;
    results();
  end
endmodule // tb_top
